// ===== verilog/uhf_pkg.sv
// Package with constants and carrier types for the half-duplex / flow-control UART port.
package uhf_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned BAUD_HZ = 115200;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
	localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2);
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [2:0] FIFO_MOVE_CYCLES = 3'h4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic LINE_IDLE = 1'b1;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		TX_IDLE = 2'b00,
		TX_START = 2'b01,
		TX_DATA = 2'b10,
		TX_STOP = 2'b11
	} uhf_tx_state_t;

	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
	} uhf_byte_t;

	typedef struct packed
	{
		logic txd;
		logic rts;
		logic receive_buffer_ctl;
		logic drive_enable_ctl;
	} uhf_pins_t;

endpackage : uhf_pkg

// ===== verilog/uhf_rx.sv
// Serial receiver for 8N1 characters, LSB first.
`timescale 1ns/1ps
module uhf_rx
	import uhf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Serial line
	input wire logic rxd,
	// Received byte
	output uhf_byte_t rx_byte
);

	typedef struct packed
	{
		logic sync1;
		logic sync2;
		logic busy;
		logic [15:0] cnt;
		logic [3:0] bitn;
		logic [7:0] shift;
		uhf_byte_t out;
	} uhf_rx_st_t;

	uhf_rx_st_t s_q;
	uhf_rx_st_t s_d;

	assign rx_byte = s_q.out;

	always_comb
	begin
		s_d = s_q;
		s_d.sync1 = rxd;
		s_d.sync2 = s_q.sync1;
		s_d.out.valid = 1'b0;
		if (!s_q.busy)
		begin
			if (!s_q.sync2)
			begin
				s_d.busy = 1'b1;
				s_d.cnt = HALF_BIT;
				s_d.bitn = 4'h0;
			end
		end
		else if (s_q.cnt != 16'h0000)
		begin
			s_d.cnt = s_q.cnt - 16'h0001;
		end
		else
		begin
			s_d.cnt = BIT_LAST;
			s_d.bitn = s_q.bitn + 4'h1;
			if (s_q.bitn == 4'h0)
			begin
				// A start bit that vanished at mid-bit was noise.
				if (s_q.sync2)
				begin
					s_d.busy = 1'b0;
				end
			end
			else if (s_q.bitn <= DATA_BITS)
			begin
				s_d.shift = {s_q.sync2, s_q.shift[7:1]};
			end
			else
			begin
				s_d.busy = 1'b0;
				s_d.out.valid = s_q.sync2;
				s_d.out.data = s_q.shift;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_q <= '{sync1: LINE_IDLE, sync2: LINE_IDLE, default: '0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule : uhf_rx

// ===== verilog/uhf_port.sv
// UART port with half-duplex transceiver control and RTS/CTS flow control.
`timescale 1ns/1ps

// Behaviour
// - Every character is eight data bits, no parity and one stop bit.
// - Half-duplex mode offers receive_buffer_ctl and drive_enable_ctl beside the data pins.
// - In half-duplex mode both control outputs are high while transmitting and low otherwise.
// - Receiver and transmitter always run independently and concurrently.
// - In flow-control mode CTS is sampled at each byte start and the byte waits until it is low.
// - A byte already being shifted out when CTS rises is finished in full.
// - A byte completed before CTS rose is never sent again.
// - In flow-control mode RTS is high while the port cannot take data and low when the receiver is ready; half-duplex mode holds it low.
// - In flow-control mode each received byte raises RTS for the few cycles it is moved to the receive FIFO.
module uhf_port
	import uhf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Mode select, high for half-duplex transceiver control
	input wire logic half_duplex,
	// Serial pins
	input wire logic rxd,
	input wire logic cts,
	output logic txd,
	output logic rts,
	output logic receive_buffer_ctl,
	output logic drive_enable_ctl,
	// Transmit byte stream
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// Receive byte stream
	output logic [7:0] rx_data,
	output logic rx_valid
);

	typedef struct packed
	{
		uhf_tx_state_t st;
		logic [15:0] cnt;
		logic [2:0] bitn;
		logic [7:0] shift;
		logic ready;
		logic [2:0] move;
		uhf_byte_t rx_out;
		uhf_pins_t pins;
	} uhf_port_st_t;

	uhf_port_st_t s_q;
	uhf_port_st_t s_d;
	uhf_byte_t rx_byte;
	logic sending;

	// --------------------------------------------------------------
	// Receiver
	// --------------------------------------------------------------
	// receiver has its own state, untouched by transmit
	uhf_rx u_rx
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.rxd(rxd),
		.rx_byte(rx_byte)
	);

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign txd = s_q.pins.txd;
	assign rts = s_q.pins.rts;
	assign receive_buffer_ctl = s_q.pins.receive_buffer_ctl;
	assign drive_enable_ctl = s_q.pins.drive_enable_ctl;
	assign tx_ready = s_q.ready;
	assign rx_data = s_q.rx_out.data;
	assign rx_valid = s_q.rx_out.valid;

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.rx_out.valid = 1'b0;
		sending = 1'b0;

		// ----------------------------------------------------------
		// Receive hand-off
		// ----------------------------------------------------------
		// each byte held in the transfer stage for a few cycles
		// The count is far shorter than a character, so bytes never overlap in it.
		if (rx_byte.valid)
		begin
			s_d.move = FIFO_MOVE_CYCLES;
			s_d.rx_out.data = rx_byte.data;
		end
		else if (s_q.move != 3'h0)
		begin
			s_d.move = s_q.move - 3'h1;
			if (s_q.move == 3'h1)
			begin
				s_d.rx_out.valid = 1'b1;
			end
		end

		// ----------------------------------------------------------
		// Transmit sequencer
		// ----------------------------------------------------------
		s_d.ready = 1'b0;
		unique case (s_q.st)
			TX_IDLE:
			begin
				s_d.pins.txd = LINE_IDLE;
				// CTS checked at start of each byte
				// a grounded CTS always lets bytes out
				// No byte is buffered, so tx_data must stand until tx_ready answers.
				if (tx_valid && !s_q.ready && (half_duplex || !cts))
				begin
					s_d.ready = 1'b1;
					s_d.shift = tx_data;
					s_d.st = TX_START;
					s_d.cnt = BIT_LAST;
					s_d.pins.txd = 1'b0;
				end
			end
			TX_START, TX_DATA:
			begin
				// CTS ignored until the stop bit ends
				sending = 1'b1;
				if (s_q.cnt != 16'h0000)
				begin
					s_d.cnt = s_q.cnt - 16'h0001;
				end
				else
				begin
					s_d.cnt = BIT_LAST;
					if (s_q.st == TX_START)
					begin
						s_d.st = TX_DATA;
						s_d.bitn = 3'h0;
						s_d.pins.txd = s_q.shift[0];
					end
					else if (s_q.bitn == 3'h7)
					begin
						s_d.st = TX_STOP;
						s_d.pins.txd = 1'b1;
					end
					else
					begin
						s_d.bitn = s_q.bitn + 3'h1;
						s_d.pins.txd = s_q.shift[s_q.bitn + 3'h1];
					end
				end
			end
			TX_STOP:
			begin
				sending = 1'b1;
				if (s_q.cnt != 16'h0000)
				begin
					s_d.cnt = s_q.cnt - 16'h0001;
				end
				else
				begin
					// byte was taken at start, so it is dropped here for good
					s_d.st = TX_IDLE;
					sending = 1'b0;
				end
			end
		endcase
		if (s_d.st != TX_IDLE)
		begin
			sending = 1'b1;
		end

		// ----------------------------------------------------------
		// Pin outputs
		// ----------------------------------------------------------
		// only the selected mode's outputs act
		if (half_duplex)
		begin
			// both controls driven in half-duplex mode
			s_d.pins.receive_buffer_ctl = sending;
			s_d.pins.drive_enable_ctl = sending;
			s_d.pins.rts = 1'b0;
		end
		else
		begin
			s_d.pins.receive_buffer_ctl = 1'b0;
			s_d.pins.drive_enable_ctl = 1'b0;
			// RTS high while the receive path is busy
			// Taken from the next count, so RTS rises in the edge that starts the hand-off.
			s_d.pins.rts = rx_byte.valid || (s_d.move != 3'h0);
		end
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			// The line idles high from the first cycle, so the host never sees a false start.
			s_q <= '{
				st: TX_IDLE,
				pins: '{txd: LINE_IDLE, default: 1'b0},
				default: '0
			};
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule : uhf_port

// ===== test/uhf_port_monitor.sv
// Checker for the port's serial pins and byte streams.
`timescale 1ns/1ps
module uhf_port_monitor
	import uhf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Serial pins and mode
	input wire logic half_duplex,
	input wire logic rxd,
	input wire logic cts,
	input wire logic txd,
	input wire logic rts,
	input wire logic receive_buffer_ctl,
	input wire logic drive_enable_ctl,
	// Byte streams
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	ctl_pair_a: assert property (receive_buffer_ctl == drive_enable_ctl)
		else $error("transceiver controls differ");
	ctl_mode_a: assert property (!half_duplex |=> !drive_enable_ctl)
		else $error("drive enable active in full duplex");
	rts_mode_a: assert property (half_duplex |=> !rts)
		else $error("rts active in half duplex");
	start_low_a: assert property (tx_ready |-> !txd)
		else $error("no start bit with byte taken");
	start_len_a: assert property (tx_ready |-> ##172 !txd)
		else $error("start bit too short");
	ctl_on_a: assert property (half_duplex && tx_ready |-> drive_enable_ctl)
		else $error("drive enable low while sending");
	ctl_off_a: assert property (half_duplex && $fell(drive_enable_ctl) |-> txd)
		else $error("drive enable dropped mid frame");
	cts_gate_a: assert property (tx_ready && !$past(half_duplex) |-> !$past(cts))
		else $error("byte started with cts high");
	rts_pulse_a: assert property ($rose(rts) |-> rts[*4] ##1 !rts)
		else $error("rts pulse length wrong");
	rx_hand_a: assert property ($fell(rts) |-> rx_valid)
		else $error("byte not handed on as rts falls");
	cover property (tx_ready && half_duplex);
	cover property (tx_ready && !half_duplex);
	cover property ($rose(rts));
endmodule : uhf_port_monitor

// ===== test/uhf_host.sv
// Host UART model facing the port's serial pins.
`timescale 1ns/1ps
module uhf_host
	import uhf_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Serial pins
	input wire logic txd,
	input wire logic rts,
	output logic rxd,
	// Decoded byte, valid for one cycle
	output uhf_byte_t got
);
	initial
	begin
		rxd = LINE_IDLE;
		got = '0;
	end
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int k = 0; k < 8 && rts; k++) @(posedge sys_clk);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge sys_clk);
			#1 rxd = f[i];
			repeat (BIT_CYCLES - 1) @(posedge sys_clk);
		end
	endtask : send_byte
	// Sample mid bit, stop must be high
	always
	begin
		@(negedge txd);
		repeat (BIT_CYCLES / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYCLES) @(posedge sys_clk);
			got.data[i] = txd;
		end
		repeat (BIT_CYCLES) @(posedge sys_clk);
		#1 got.valid = txd;
		@(posedge sys_clk);
		#1 got.valid = 1'b0;
	end
endmodule : uhf_host

// ===== test/test_uhf_port.sv
// Self-checking bench for the UART port.
`timescale 1ns/1ps
module test_uhf_port
	import uhf_pkg::*;
;
	logic sys_clk = 0, rst = 1, half_duplex = 1, cts = 1, tx_valid = 0;
	logic [7:0] tx_data = 8'h00, rx_data;
	logic txd, rts, receive_buffer_ctl, drive_enable_ctl, tx_ready, rx_valid, rxd;
	uhf_byte_t got;
	logic [31:0] lfsr = 32'h22edd767;
	logic [7:0] txq[$], rxq[$];
	int n_mismatch = 0, num_checks = 0, k;
	always #25 sys_clk = ~sys_clk;
	uhf_port uhf_port_i(.sys_clk(sys_clk), .rst(rst), .half_duplex(half_duplex), .rxd(rxd),
		.cts(cts), .txd(txd), .rts(rts), .receive_buffer_ctl(receive_buffer_ctl),
		.drive_enable_ctl(drive_enable_ctl), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
	uhf_host uhf_host_i(.sys_clk(sys_clk), .txd(txd), .rts(rts), .rxd(rxd), .got(got));
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : next_rand
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("Error at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic send(input logic [7:0] b);
		int w;
		@(posedge sys_clk);
		#1 tx_data = b;
		tx_valid = 1;
		txq.push_back(b);
		for (w = 0; w < 4000 && tx_ready !== 1'b1; w++) @(posedge sys_clk);
		if (w == 4000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
		#1 tx_valid = 0;
	endtask : send
	task automatic hsend(input logic [7:0] b);
		rxq.push_back(b);
		uhf_host_i.send_byte(b);
	endtask : hsend
	always @(posedge sys_clk)
	begin
		if (rx_valid === 1'b1) check(rx_data, rxq.pop_front());
		if (got.valid === 1'b1) check(got.data, txq.pop_front());
	end
	initial
	begin
		repeat (4) @(posedge sys_clk);
		#1 rst = 0;
		// Half duplex with cts high, both directions at once.
		fork
			send(lfsr[7:0]);
			hsend(lfsr[15:8]);
		join
		repeat (300) @(posedge sys_clk);
		#1 half_duplex = 0;
		lfsr = next_rand(lfsr);
		fork
			send(lfsr[7:0]);
			hsend(lfsr[15:8]);
			begin
				repeat (300)
				begin
					@(posedge sys_clk);
					check({7'h00, txd}, 8'h01);
				end
				#1 cts = 0;
				repeat (600) @(posedge sys_clk);
				#1 cts = 1;
			end
		join
		fork
			send(lfsr[23:16]);
			begin
				repeat (2500) @(posedge sys_clk);
				#1 cts = 0;
			end
		join
		for (k = 0; k < 4000 && (txq.size() + rxq.size()) > 0; k++) @(posedge sys_clk);
		if (k == 4000) n_mismatch++;
		tally_and_finish();
	end
endmodule : test_uhf_port
bind uhf_port uhf_port_monitor uhf_port_monitor_i(.sys_clk(sys_clk), .rst(rst),
	.half_duplex(half_duplex), .rxd(rxd), .cts(cts), .txd(txd), .rts(rts),
	.receive_buffer_ctl(receive_buffer_ctl), .drive_enable_ctl(drive_enable_ctl),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
	.rx_valid(rx_valid));
